// file: common/param_read_regs.svh
// opcodes, byte counts and table contents for the identifier and parameter table reads
`ifndef PARAM_READ_REGS_SVH
`define PARAM_READ_REGS_SVH

// ============================================================
// command codes
`define OP_SERIAL_ID        8'h4B
`define OP_PARAM_TABLE      8'h5A

// ============================================================
// frame byte and bit counts, each LAST value held as count minus one, plus counter and address constants
`define ID_DUMMY_LAST       2'h3
`define TABLE_ADDR_LAST     2'h2
`define TABLE_DUMMY_LAST    2'h0
`define BYTE_CNT_ZERO       2'h0
`define BIT_LAST            3'h7
`define BIT_ONE             3'h1
`define ADDR_ZERO           24'h000000
`define ADDR_STEP           24'h000001

// ============================================================
// core side
`define FUSE_SETTLE_LAST    2'h2
`define FRAME_COUNT_STEP    8'h01

// ============================================================
// table layout
`define TABLE_PAGE_ZERO     16'h0000
`define HDR_LAST            8'h17
`define STD_BASE            8'h30
`define STD_LAST            8'h53
`define UNUSED_BYTE         8'hFF

// header double words, lowest address in the low byte
`define HDR_SIGNATURE       32'h50444653
`define HDR_REVISION_DW     32'hFF010100
`define HDR_STD_DW0         32'h09010000
`define HDR_STD_DW1         32'hFF000030
`define HDR_VND_DW0_TOP     24'h030100
`define HDR_VND_DW1         32'hFF000060

// standard parameter table, nine double words from the table base
`define STD_DW0             32'hFFF920E5
`define STD_DW1_DENSITY     32'h007FFFFF
`define STD_DW2             32'h6B08EB44
`define STD_DW3             32'hBB803B08
`define STD_DW4             32'hFFFFFFFE
`define STD_DW5             32'hFF00FFFF
`define STD_DW6             32'hEB44FFFF
`define STD_DW7             32'h520F200C
`define STD_DW8             32'h8108D810

`endif

// file: common/param_read_pkg.sv
// types for the identifier and parameter table read block
package param_read_pkg;

    typedef enum logic [4:0] {
        st_cmd   = 5'h01,
        st_addr  = 5'h02,
        st_dummy = 5'h04,
        st_data  = 5'h08,
        st_skip  = 5'h10
    } link_state_type;

    typedef struct packed {
        link_state_type state;
        logic [2:0]     bit_cnt;
        logic [6:0]     shift;
        logic [1:0]     byte_cnt;
        logic [23:0]    addr;
        logic           is_id;
        logic           ld_meta;
        logic           ld_sync;
    } link_regs_type;

    typedef struct packed {
        logic           cs_meta;
        logic           cs_sync;
        logic           cs_prev;
        logic           frame_active;
        logic [1:0]     settle;
        logic           loaded;
        logic [127:0]   uid;
        logic [7:0]     frame_count;
    } core_regs_type;

endpackage : param_read_pkg

// file: hdl/table_byte_source.sv
// byte source for identifier and parameter table output
`timescale 1ns/100ps
`include "param_read_regs.svh"

module table_byte_source #(
    // arbitrary vendor identity value, not tied to any maker
    parameter logic [7:0] VENDOR_ID = 8'hA7
) (
    input  wire logic [23:0]  addr,
    input  wire logic         is_id,
    input  wire logic         id_ok,
    input  wire logic [127:0] uid,
    output logic      [7:0]   data
);

    localparam logic [191:0] HDR = {`HDR_VND_DW1, `HDR_VND_DW0_TOP, VENDOR_ID,
                                    `HDR_STD_DW1, `HDR_STD_DW0,
                                    `HDR_REVISION_DW, `HDR_SIGNATURE};
    localparam logic [287:0] STD = {`STD_DW8, `STD_DW7, `STD_DW6, `STD_DW5,
                                    `STD_DW4, `STD_DW3, `STD_DW2,
                                    `STD_DW1_DENSITY, `STD_DW0};

    logic [7:0] low;
    logic [7:0] std_off;
    logic [3:0] id_sel;

    assign low     = addr[7:0];
    assign std_off = low - `STD_BASE;
    assign id_sel  = ~addr[3:0];

    always_comb begin
        data = `UNUSED_BYTE;
        if (is_id) begin
            // first byte out is the top of the word
            if (id_ok) begin
                data = uid[{id_sel, 3'h0} +: 8]; // RQ3 RQ16
            end
        end else if (addr[23:8] == `TABLE_PAGE_ZERO) begin
            if (low <= `HDR_LAST) begin
                data = HDR[{low[4:0], 3'h0} +: 8]; // RQ7 RQ8 RQ9 RQ10
            end else if (low >= `STD_BASE && low <= `STD_LAST) begin
                data = STD[{std_off[5:0], 3'h0} +: 8]; // RQ11 RQ12 RQ13 RQ14 RQ15 RQ17
            end
        end
    end

endmodule : table_byte_source

// file: hdl/param_read_device.sv
// serial identifier and parameter table read logic of the flash device
`timescale 1ns/100ps
`include "param_read_regs.svh"

// Summary of operation
// RQ1 - command byte 4Bh with select low starts the identifier read
// RQ2 - four dummy bytes follow that command; their content is ignored
// RQ3 - then the fixed 128-bit per-part identifier is shifted out
// RQ4 - opcode 5Ah plus three address bytes picks the first table byte
// RQ5 - exactly one dummy byte follows the address before table data
// RQ6 - data keeps flowing until select rises, which may happen any time
// RQ7 - header gives signature, revision 1.0 and one extra parameter header
// RQ8 - header bytes 07h, 0Fh and 17h always read FFh
// RQ9 - first header: standard table, rev 1.0, nine words, pointer 30h
// RQ10 - second header: vendor table, rev 1.0, three words, pointer 60h
// RQ11 - byte 30h reads E5h, byte 31h reads the 4 KB erase opcode 20h
// RQ12 - byte 32h reads F9h, byte 33h reads FFh
// RQ13 - quad I/O read: four wait states, two mode bits, opcode EBh
// RQ14 - quad output read: eight wait states, no mode bits, opcode 6Bh
// RQ15 - density word reads 007FFFFFh for the 8-megabit array
// RQ16 - byte address steps after each byte; bits leave MSB first
// RQ17 - byte 3Dh holds 3Bh and byte 3Fh holds BBh
module param_read_device (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [127:0] uid_fuse,
    input  wire logic         sclk,
    input  wire logic         cs_n,
    input  wire logic         si,
    output logic              so,
    output logic              so_en_n,
    output logic              frame_active,
    output logic              uid_loaded,
    output logic [7:0]        frame_count
);

    // ============================================================
    // core domain state

    param_read_pkg::core_regs_type core_r;
    param_read_pkg::core_regs_type core_nxt;

    // ============================================================
    // link domain state

    param_read_pkg::link_regs_type link_r;
    param_read_pkg::link_regs_type link_nxt;

    logic       so_r;
    logic       so_en_n_r;
    logic [7:0] full_byte;
    logic       byte_done;
    logic [7:0] out_byte;

    // ============================================================
    // core domain: identifier capture and frame status

    always_comb begin
        core_nxt = core_r;

        // select is a pin, so it passes two flops first
        core_nxt.cs_meta = cs_n;
        core_nxt.cs_sync = core_r.cs_meta;
        core_nxt.cs_prev = core_r.cs_sync;

        core_nxt.frame_active = ~core_r.cs_sync;

        if (core_r.cs_prev && !core_r.cs_sync) begin
            core_nxt.frame_count = core_r.frame_count + `FRAME_COUNT_STEP;
        end

        // fuse word is sampled a few cycles after release,
        // never under reset, then held for the link side
        if (!core_r.loaded) begin
            if (core_r.settle == `FUSE_SETTLE_LAST) begin
                core_nxt.uid    = uid_fuse; // RQ3
                core_nxt.loaded = 1'b1;
            end else begin
                core_nxt.settle = core_r.settle + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_r.cs_meta      <= 1'b1;
            core_r.cs_sync      <= 1'b1;
            core_r.cs_prev      <= 1'b1;
            core_r.frame_active <= 1'b0;
            core_r.settle       <= 2'h0;
            core_r.loaded       <= 1'b0;
            core_r.uid          <= 128'h0;
            core_r.frame_count  <= 8'h00;
        end else begin
            core_r <= core_nxt;
        end
    end

    assign frame_active = core_r.frame_active;
    assign uid_loaded   = core_r.loaded;
    assign frame_count  = core_r.frame_count;

    // ============================================================
    // link domain: command, address and dummy decoding
    //
    // select high clears the whole link state at once; the serial
    // clock may be still between frames, so nothing here waits for
    // an edge after select rises

    assign full_byte = {link_r.shift, si};
    assign byte_done = (link_r.bit_cnt == `BIT_LAST);

    always_comb begin
        link_nxt = link_r;

        // identifier word is held steady once loaded; this level
        // gates its use, so the word itself needs no sync stage
        link_nxt.ld_meta = core_r.loaded;
        link_nxt.ld_sync = link_r.ld_meta;

        link_nxt.shift   = full_byte[6:0];
        link_nxt.bit_cnt = link_r.bit_cnt + `BIT_ONE;

        if (byte_done) begin
            case (link_r.state)
                param_read_pkg::st_cmd: begin
                    if (full_byte == `OP_SERIAL_ID) begin
                        link_nxt.state    = param_read_pkg::st_dummy; // RQ1
                        link_nxt.byte_cnt = `ID_DUMMY_LAST; // RQ2
                        link_nxt.addr     = `ADDR_ZERO;
                        link_nxt.is_id    = 1'b1;
                    end else if (full_byte == `OP_PARAM_TABLE) begin
                        link_nxt.state    = param_read_pkg::st_addr; // RQ4
                        link_nxt.byte_cnt = `TABLE_ADDR_LAST; // RQ4
                        link_nxt.is_id    = 1'b0;
                    end else begin
                        // other commands belong to other blocks
                        link_nxt.state = param_read_pkg::st_skip;
                    end
                end
                param_read_pkg::st_addr: begin
                    link_nxt.addr = {link_r.addr[15:0], full_byte}; // RQ4
                    if (link_r.byte_cnt == `BYTE_CNT_ZERO) begin
                        link_nxt.state    = param_read_pkg::st_dummy;
                        link_nxt.byte_cnt = `TABLE_DUMMY_LAST; // RQ5
                    end else begin
                        link_nxt.byte_cnt = link_r.byte_cnt - 2'h1;
                    end
                end
                param_read_pkg::st_dummy: begin
                    // dummy content is never looked at
                    if (link_r.byte_cnt == `BYTE_CNT_ZERO) begin
                        link_nxt.state = param_read_pkg::st_data; // RQ2 RQ5
                    end else begin
                        link_nxt.byte_cnt = link_r.byte_cnt - 2'h1;
                    end
                end
                param_read_pkg::st_data: begin
                    // runs on with no end of its own until select rises
                    link_nxt.addr = link_r.addr + `ADDR_STEP; // RQ16 RQ6
                end
                param_read_pkg::st_skip: begin
                    link_nxt.state = param_read_pkg::st_skip;
                end
                default: begin
                    link_nxt.state = param_read_pkg::st_skip;
                end
            endcase
        end
    end

    // select acts as the link reset; it takes only constants
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            link_r.state    <= param_read_pkg::st_cmd;
            link_r.bit_cnt  <= 3'h0;
            link_r.shift    <= 7'h00;
            link_r.byte_cnt <= 2'h0;
            link_r.addr     <= 24'h000000;
            link_r.is_id    <= 1'b0;
            link_r.ld_meta  <= 1'b0;
            link_r.ld_sync  <= 1'b0;
        end else begin
            link_r <= link_nxt; // RQ6
        end
    end

    // ============================================================
    // link domain: byte lookup and serial output

    table_byte_source u_table_byte_source (
        .addr  (link_r.addr),
        .is_id (link_r.is_id),
        .id_ok (link_r.ld_sync),
        .uid   (core_r.uid),
        .data  (out_byte)
    );

    // output moves on the falling edge so it is stable at the
    // host's rising sample edge; bit counter picks MSB first
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so_r      <= 1'b0;
            so_en_n_r <= 1'b1;
        end else if (link_r.state == param_read_pkg::st_data) begin
            so_r      <= out_byte[~link_r.bit_cnt]; // RQ16 RQ3
            so_en_n_r <= 1'b0; // RQ6
        end else begin
            so_r      <= 1'b0;
            so_en_n_r <= 1'b1;
        end
    end

    assign so      = so_r;
    assign so_en_n = so_en_n_r;

endmodule : param_read_device

// file: tb/param_read_assertions.sv
// concurrent checks on the read block ports
`timescale 1ns/100ps
module param_read_assertions (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       cs_n,
    input wire logic       so,
    input wire logic       so_en_n,
    input wire logic       frame_active,
    input wire logic       uid_loaded,
    input wire logic [7:0] frame_count
);
    // ========================================
    // select low time, saturating
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    always_comb begin
        low_cnt_nxt = cs_n ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
    end
    always_ff @(posedge core_clk) begin
        low_cnt_r <= reset ? 8'h00 : low_cnt_nxt;
    end
    // ========================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence sel_fall;
        $fell(cs_n);
    endsequence
    sequence sync_seen;
        ##[1:4] frame_active;
    endsequence
    en_idle_a: assert property (cs_n |-> so_en_n) else $error("output enabled while deselected");
    so_quiet_a: assert property (so_en_n |-> !so) else $error("output not quiet while disabled");
    reset_clear_a: assert property (disable iff (1'b0) reset |=> !frame_active && !uid_loaded
        && frame_count == 8'h00) else $error("status not cleared by reset");
    load_time_a: assert property ($fell(reset) |-> ##[1:4] uid_loaded) else $error("identifier not captured");
    load_hold_a: assert property (uid_loaded |=> uid_loaded) else $error("identifier capture lost");
    active_rise_a: assert property (sel_fall |-> sync_seen) else $error("frame not seen active");
    count_due_a: assert property (sel_fall |-> ##[1:8] $changed(frame_count)) else $error("frame not counted");
    count_step_a: assert property (!$past(reset) && $changed(frame_count)
        |-> frame_count == $past(frame_count) + 8'h01) else $error("frame count jumped");
    active_fall_a: assert property (cs_n [*6] |-> !frame_active) else $error("frame active after deselect");
    data_late_a: assert property ($fell(so_en_n) |-> low_cnt_r >= 8'h3C && frame_active)
        else $error("output began too early");
endmodule : param_read_assertions

bind param_read_device param_read_assertions i_param_read_assertions (.core_clk(core_clk), .reset(reset),
    .cs_n(cs_n), .so(so), .so_en_n(so_en_n), .frame_active(frame_active), .uid_loaded(uid_loaded),
    .frame_count(frame_count));

// file: tb/spi_host_model.sv
// host controller model driving select, serial clock and input
`timescale 1ns/100ps
module spi_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_en_n
);
    localparam time HALF = 32;
    logic [7:0] rx [0:23];
    logic       en_seen;
    // ========================================
    // serial clock stands low outside frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        en_seen = 1'b0;
    end
    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            si = b[i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
    endtask : send_byte
    task frame(input logic [7:0] op, input int nadr, input logic [23:0] a, input int ndum, input int nbits);
        en_seen = 1'b0;
        cs_n = 1'b0;
        #HALF send_byte(op);
        for (int i = 0; i < nadr; i++) send_byte(a[8*(2-i) +: 8]);
        // dummy content must not matter
        for (int i = 0; i < ndum; i++) send_byte(8'hA5);
        for (int i = 0; i < nbits; i++) begin
            si = ~si;
            #HALF rx[i/8][7-i%8] = so;
            en_seen = en_seen | ~so_en_n;
            sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        #(10*HALF);
    endtask : frame
endmodule : spi_host_model

// file: tb/param_read_device_test.sv
// testbench for the identifier and parameter table read block
`timescale 1ns/100ps
module param_read_device_test;
    localparam logic [127:0] UID = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    logic         core_clk;
    logic         reset;
    logic [127:0] uid_fuse;
    logic         sclk, cs_n, si, so, so_en_n, frame_active, uid_loaded;
    logic [7:0]   frame_count;
    int           errors, comparisons, cycles;
    param_read_device i_param_read_device (.core_clk(core_clk), .reset(reset), .uid_fuse(uid_fuse),
        .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_en_n(so_en_n), .frame_active(frame_active),
        .uid_loaded(uid_loaded), .frame_count(frame_count));
    spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_en_n(so_en_n));
    // ========================================
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    // ========================================
    // tasks
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task read_run(input logic [7:0] op, input int nadr, input logic [23:0] a, input int n, input logic [191:0] exp);
        i_spi_host_model.frame(op, nadr, a, (op == 8'h4B) ? 4 : 1, n*8);
        for (int i = 0; i < n; i++) check(i_spi_host_model.rx[i], exp[8*(n-1-i) +: 8]);
    endtask : read_run
    task final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // ========================================
    // tests
    initial begin
        reset = 1'b1;
        uid_fuse = UID;
        repeat (6) @(posedge core_clk);
        check({frame_count[6:0], uid_loaded}, 8'h00);
        #1 reset = 1'b0;
        repeat (6) @(posedge core_clk);
        check({7'h00, uid_loaded}, 8'h01);
        $display("test reset done");
        // one byte past the end shows the identifier wrap
        read_run(8'h4B, 0, 24'h000000, 17, {56'h0, UID, UID[127:120]});
        $display("test identifier done");
        read_run(8'h5A, 3, 24'h000000, 24, 192'h53464450000101FF00000109300000FFA7000103600000FF);
        read_run(8'h5A, 3, 24'h000030, 16, 192'hE520F9FFFFFF7F0044EB086B083B80BB);
        read_run(8'h5A, 3, 24'h000052, 3, 192'h0881FF);
        read_run(8'h5A, 3, 24'h000100, 1, 192'hFF);
        $display("test table done");
        i_spi_host_model.frame(8'h5A, 3, 24'h000000, 1, 11);
        check(i_spi_host_model.rx[0], 8'h53);
        read_run(8'h5A, 3, 24'h000000, 2, 192'h5346);
        $display("test abort done");
        i_spi_host_model.frame(8'h03, 3, 24'h000000, 1, 16);
        check({7'h00, i_spi_host_model.en_seen}, 8'h00);
        @(posedge core_clk);
        check(frame_count, 8'h08);
        check({7'h00, frame_active}, 8'h00);
        $display("test refused done");
        final_report();
    end
endmodule : param_read_device_test
